/* common/pmm_defs.vh */
// constants of the paged management memory block
`ifndef PMM_DEFS_VH
`define PMM_DEFS_VH

// ==========================================================
// memory map of the management view
`define PMM_SEL_ADDR 8'h7F
`define PMM_ADV_LO_OFF 7'h02
`define PMM_ADV_LO_P3 2
`define PMM_ADV_UP_OFF 7'h43
`define PMM_ADV_UP_P2 7
`define PMM_ADV_UP_P1 6
`define PMM_ADV_UP_P20 0

// ==========================================================
// page numbers written into the page select byte
`define PMM_PG_ID 8'h00
`define PMM_PG_1 8'h01
`define PMM_PG_2 8'h02
`define PMM_PG_3 8'h03
`define PMM_PG_20 8'h20
`define PMM_PG_21 8'h21

// ==========================================================
// storage slots, 128 bytes each
`define PMM_SLOT_LOW 3'h0
`define PMM_SLOT_ID 3'h1
`define PMM_SLOT_1 3'h2
`define PMM_SLOT_2 3'h3
`define PMM_SLOT_3 3'h4
`define PMM_SLOT_20 3'h5
`define PMM_SLOT_21 3'h6

// ==========================================================
// software register byte offsets
`define PMM_REG_CTRL 8'h00
`define PMM_REG_STAT 8'h04
`define PMM_REG_MASK 8'h08
`define PMM_REG_PAGE 8'h0C
`define PMM_REG_MADR 8'h10
`define PMM_REG_MDAT 8'h14

// ==========================================================
// event bits of status and mask, and reset values
`define PMM_EV_HWR 0
`define PMM_EV_REJ 1
`define PMM_EV_SEL 2
`define PMM_CTRL_RST 1'h1
`define PMM_MASK_RST 3'h0
`define PMM_PAGE_RST 8'h00

`endif

/* src/pmm_top.v */
// paged management memory with serial host port and bus registers
//
// Behaviour
// - lower 128-byte page always reachable
// - one 128-byte upper page visible at once
// - lower page holds flags and monitors contiguously
// - upper page zero always holds identity data
// - host writes to page zero ignored
// - page one presence in byte 195 bit 6
// - page two user area, byte 195 bit 7
// - page three presence in byte 2 bit 2
// - pages 20h and 21h hold extra monitoring
// - pages 20h/21h advertised by byte 195 bit 0
// - reserved and vendor page numbers unsupported here
// - unsupported page select reverts to zero
// - reached over two-wire serial management port
`include "pmm_defs.vh"

module pmm_top
#(
    parameter [6:0] DEV_ADDR = 7'h50,
    parameter HAS_P1 = 1'b0,
    parameter HAS_P2 = 1'b1,
    parameter HAS_P3 = 1'b1,
    parameter HAS_P20 = 1'b1
)
(
    input wire I_CLOCK,         // 25 MHz system clock
    input wire I_RESET,         // async reset, high
    input wire I_HSEL,          // slave select
    input wire [31:0] I_HADDR,  // byte address
    input wire [1:0] I_HTRANS,  // transfer type
    input wire I_HWRITE,        // write when high
    input wire [2:0] I_HSIZE,   // word transfers only
    input wire [31:0] I_HWDATA, // write data
    input wire I_HREADY,        // bus ready
    output reg [31:0] O_HRDATA, // read data
    output reg O_HREADYOUT,     // slave ready
    output reg O_HRESP,         // always okay
    input wire I_SCL,           // serial clock from host
    input wire I_SDA,           // serial data level
    output reg O_SDA,           // serial data drive value
    output wire O_SDA_OE_N,     // low while pulling data low
    output reg O_IRQ            // level interrupt
);

    localparam MEM_BYTES = 7 * 128;

    // ======================================================
    // state
    reg [7:0] mem [0:MEM_BYTES-1];
    reg [7:0] page_q;
    reg [7:0] ser_rd_q;
    reg en_q;
    reg [2:0] mask_q;
    reg [2:0] stat_q;
    reg [9:0] madr_q;
    reg ap_q;
    reg aw_q;
    reg [7:0] aa_q;
    reg [2:0] stat_d;
    reg [7:0] rbyte;
    reg [2:0] rslot;
    reg [2:0] wslot;
    reg [2:0] ev;
    reg [31:0] rmux;
    integer i;

    wire ser_wr;
    wire [7:0] ser_wa;
    wire [7:0] ser_wd;
    wire [7:0] ser_ptr;

    // ======================================================
    // page number to storage slot
    function [2:0] slot_of;
        input [7:0] pg;
        begin
            case (pg)
            `PMM_PG_1: slot_of = `PMM_SLOT_1;
            `PMM_PG_2: slot_of = `PMM_SLOT_2;
            `PMM_PG_3: slot_of = `PMM_SLOT_3;
            `PMM_PG_20: slot_of = `PMM_SLOT_20;
            `PMM_PG_21: slot_of = `PMM_SLOT_21;
            default: slot_of = `PMM_SLOT_ID;
            endcase
        end
    endfunction

    // whether a page number is implemented by this build
    function supp;
        input [7:0] pg;
        begin
            case (pg)
            `PMM_PG_ID: supp = 1'b1;
            `PMM_PG_1: supp = HAS_P1;
            `PMM_PG_2: supp = HAS_P2;
            `PMM_PG_3: supp = HAS_P3;
            `PMM_PG_20: supp = HAS_P20;
            `PMM_PG_21: supp = HAS_P20;
            default: supp = 1'b0;
            endcase
        end
    endfunction

    // ======================================================
    // serial host port
    pmm_twi #(
        .DEV_ADDR(DEV_ADDR)
    ) u_twi (
        .i_clk(I_CLOCK),
        .i_rst(I_RESET),
        .i_en(en_q),
        .i_scl(I_SCL),
        .i_sda(I_SDA),
        .i_rdata(ser_rd_q),
        .o_sda_oe_n(O_SDA_OE_N),
        .o_wr(ser_wr),
        .o_wa(ser_wa),
        .o_wd(ser_wd),
        .o_ptr(ser_ptr)
    );

    // ======================================================
    // host view of a byte, with advertisement bits forced
    always @*
    begin
        // upper half follows the page select, lower half never does
        rslot = ser_ptr[7] ? slot_of(page_q) : `PMM_SLOT_LOW;
        rbyte = mem[{rslot, ser_ptr[6:0]}];
        if (ser_ptr == `PMM_SEL_ADDR)
            rbyte = page_q;
        if (!ser_ptr[7] && ser_ptr[6:0] == `PMM_ADV_LO_OFF)
            rbyte[`PMM_ADV_LO_P3] = HAS_P3;
        if (ser_ptr[7] && rslot == `PMM_SLOT_ID
            && ser_ptr[6:0] == `PMM_ADV_UP_OFF)
        begin
            rbyte[`PMM_ADV_UP_P1] = HAS_P1;
            rbyte[`PMM_ADV_UP_P2] = HAS_P2;
            rbyte[`PMM_ADV_UP_P20] = HAS_P20;
        end
        // retired page reads as zero
        if (ser_ptr[7] && rslot == `PMM_SLOT_1)
            rbyte = 8'h00;
    end

    // serial clock is far slower, so one cycle of lag is harmless
    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
            ser_rd_q <= 8'h00;
        else
            ser_rd_q <= rbyte;
    end

    // ======================================================
    // host write classification and events
    always @*
    begin
        wslot = ser_wa[7] ? slot_of(page_q) : `PMM_SLOT_LOW;
        ev = 3'h0;
        if (ser_wr)
        begin
            if (ser_wa == `PMM_SEL_ADDR)
            begin
                ev[`PMM_EV_REJ] = ~supp(ser_wd);
                ev[`PMM_EV_SEL] = supp(ser_wd);
            end
            else if (!(ser_wa[7] && (wslot == `PMM_SLOT_ID
                     || wslot == `PMM_SLOT_1)))
                ev[`PMM_EV_HWR] = 1'b1;
        end
    end

    // ======================================================
    // page select byte
    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
            page_q <= `PMM_PAGE_RST;
        else if (ser_wr && ser_wa == `PMM_SEL_ADDR)
        begin
            if (supp(ser_wd))
                page_q <= ser_wd;
            else
                page_q <= `PMM_PG_ID;
        end
    end

    // ======================================================
    // bus handshake: one wait cycle, two when a byte store write clashes with the host port, gives a registered answer
    wire accept = I_HSEL & I_HTRANS[1] & I_HREADY;
    wire stall = ap_q & aw_q & (aa_q == `PMM_REG_MDAT) & ser_wr;
    wire done = ap_q & ~stall;
    wire rd_done = done & ~aw_q;
    wire wr_done = done & aw_q;

    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            ap_q <= 1'b0;
            aw_q <= 1'b0;
            aa_q <= 8'h00;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            O_HRDATA <= 32'h00000000;
        end
        else if (accept)
        begin
            ap_q <= 1'b1;
            aw_q <= I_HWRITE;
            aa_q <= I_HADDR[7:0];
            O_HREADYOUT <= 1'b0;
        end
        else if (done)
        begin
            ap_q <= 1'b0;
            O_HREADYOUT <= 1'b1;
            O_HRDATA <= aw_q ? 32'h00000000 : rmux;
        end
    end

    // ======================================================
    // read mux, unmapped offsets read as zero
    always @*
    begin
        case (aa_q)
        `PMM_REG_CTRL: rmux = {31'h00000000, en_q};
        `PMM_REG_STAT: rmux = {29'h00000000, stat_q};
        `PMM_REG_MASK: rmux = {29'h00000000, mask_q};
        `PMM_REG_PAGE: rmux = {24'h000000, page_q};
        `PMM_REG_MADR: rmux = {22'h000000, madr_q};
        `PMM_REG_MDAT: rmux = {24'h000000, mem[madr_q]};
        default: rmux = 32'h00000000;
        endcase
    end

    // ======================================================
    // control registers written by software
    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            en_q <= `PMM_CTRL_RST;
            mask_q <= `PMM_MASK_RST;
            madr_q <= 10'h000;
        end
        else if (wr_done)
        begin
            case (aa_q)
            `PMM_REG_CTRL: en_q <= I_HWDATA[0];
            `PMM_REG_MASK: mask_q <= I_HWDATA[2:0];
            `PMM_REG_MADR: madr_q <= I_HWDATA[9:0];
            default: madr_q <= madr_q;
            endcase
        end
    end

    // ======================================================
    // sticky status: a read clears, a new event still wins
    always @*
    begin
        stat_d = stat_q;
        if (rd_done && aa_q == `PMM_REG_STAT)
            stat_d = 3'h0;
        stat_d = stat_d | ev;
    end

    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            stat_q <= 3'h0;
            O_IRQ <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            O_IRQ <= |(stat_d & mask_q);
        end
    end

    // ======================================================
    // byte store: host port first, the bus waits on a clash
    // clearing at reset costs area but keeps reads defined
    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            for (i = 0; i < MEM_BYTES; i = i + 1)
                mem[i] <= 8'h00;
        end
        else if (ser_wr && ser_wa != `PMM_SEL_ADDR)
        begin
            // identity page and retired page stay untouched
            if (!(ser_wa[7] && (wslot == `PMM_SLOT_ID
                || wslot == `PMM_SLOT_1)))
                mem[{wslot, ser_wa[6:0]}] <= ser_wd;
        end
        else if (wr_done && aa_q == `PMM_REG_MDAT
                 && madr_q < MEM_BYTES)
            mem[madr_q] <= I_HWDATA[7:0];
    end

    // ======================================================
    // open-drain data line only ever pulls low
    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
            O_SDA <= 1'b0;
        else
            O_SDA <= 1'b0;
    end

endmodule

/* src/pmm_twi.v */
// two-wire serial slave engine with byte pointer
module pmm_twi
#(
    parameter [6:0] DEV_ADDR = 7'h50
)
(
    input wire i_clk,          // system clock
    input wire i_rst,          // async reset, high
    input wire i_en,           // link enable
    input wire i_scl,          // serial clock from host
    input wire i_sda,          // serial data level
    input wire [7:0] i_rdata,  // byte at o_ptr
    output reg o_sda_oe_n,     // low while pulling data low
    output reg o_wr,           // one-cycle host write pulse
    output reg [7:0] o_wa,     // host write address
    output reg [7:0] o_wd,     // host write data
    output reg [7:0] o_ptr     // current byte pointer
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_DEV = 5'h02;
    localparam [4:0] S_ADR = 5'h04;
    localparam [4:0] S_WR = 5'h08;
    localparam [4:0] S_RD = 5'h10;

    reg [4:0] st_q;
    reg scl_q;
    reg sda_q;
    reg scl_p;
    reg sda_p;
    reg [7:0] sh_q;
    reg [7:0] tx_q;
    reg [3:0] cnt_q;

    wire rise = scl_q & ~scl_p;
    wire fall = ~scl_q & scl_p;
    wire start = scl_q & scl_p & sda_p & ~sda_q;
    wire stop = scl_q & scl_p & ~sda_p & sda_q;

    // ======================================================
    // bit engine: sample on rising clock, drive on falling
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= S_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            cnt_q <= 4'h0;
            o_sda_oe_n <= 1'b1;
            o_wr <= 1'b0;
            o_wa <= 8'h00;
            o_wd <= 8'h00;
            o_ptr <= 8'h00;
        end
        else
        begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            scl_p <= scl_q;
            sda_p <= sda_q;
            o_wr <= 1'b0;
            if (!i_en || stop)
            begin
                st_q <= S_IDLE;
                o_sda_oe_n <= 1'b1;
            end
            else if (start)
            begin
                // repeated start keeps the pointer for random reads
                st_q <= S_DEV;
                cnt_q <= 4'h0;
                o_sda_oe_n <= 1'b1;
            end
            else if (rise && st_q != S_IDLE)
            begin
                if (cnt_q < 4'h8)
                begin
                    sh_q <= {sh_q[6:0], sda_q};
                    cnt_q <= cnt_q + 4'h1;
                end
                else
                begin
                    cnt_q <= 4'h9;
                    if (st_q == S_RD && sda_q)
                        st_q <= S_IDLE; // host nack ends the read
                end
            end
            else if (fall)
            begin
                case (cnt_q)
                4'h8:
                begin
                    case (st_q)
                    S_DEV:
                    begin
                        if (sh_q[7:1] == DEV_ADDR)
                        begin
                            o_sda_oe_n <= 1'b0;
                            st_q <= sh_q[0] ? S_RD : S_ADR;
                        end
                        else
                            st_q <= S_IDLE;
                    end
                    S_ADR:
                    begin
                        o_ptr <= sh_q;
                        o_sda_oe_n <= 1'b0;
                        st_q <= S_WR;
                    end
                    S_WR:
                    begin
                        o_wr <= 1'b1;
                        o_wa <= o_ptr;
                        o_wd <= sh_q;
                        o_ptr <= o_ptr + 8'h01;
                        o_sda_oe_n <= 1'b0;
                    end
                    default: o_sda_oe_n <= 1'b1;
                    endcase
                end
                4'h9:
                begin
                    cnt_q <= 4'h0;
                    if (st_q == S_RD)
                    begin
                        o_sda_oe_n <= i_rdata[7];
                        tx_q <= {i_rdata[6:0], 1'b0};
                        o_ptr <= o_ptr + 8'h01;
                    end
                    else
                        o_sda_oe_n <= 1'b1;
                end
                default:
                begin
                    if (st_q == S_RD)
                    begin
                        o_sda_oe_n <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                endcase
            end
        end
    end

endmodule

/* tb/paged_management_memory_map_tb_top.sv */
// testbench for the paged management memory
`include "pmm_defs.vh"
module paged_management_memory_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, hsel, hwrite, hready, hresp, o_sda, oe_n, irq;
    logic scl, sda_low;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] q;
    logic [7:0] bad[7] = '{8'h01, 8'h04, 8'h1F, 8'h22, 8'h7F, 8'h80, 8'hFF};
    logic [7:0] good[4] = '{8'h02, 8'h03, 8'h20, 8'h21};
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    wire sda = !sda_low && (oe_n || o_sda);
    // ==========================================================
    // design, host model and clock
    pmm_top dut (.I_CLOCK(clk), .I_RESET(rst), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_N(oe_n),
        .O_IRQ(irq));
    pmm_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            num_errors++;
            test_done;
        end
    end
    // ==========================================================
    // compare, bus access and closing report
    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        // hready is read just after the edge, before the slave updates it
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] m, e);
        logic [31:0] t;
        bus(1'b0, a, 32'h0, t);
        chk(n, t & m, e);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rchk("ctrl", `PMM_REG_CTRL, 32'hFFFFFFFF, 32'h1);
        rchk("mask", `PMM_REG_MASK, 32'hFFFFFFFF, 32'h0);
        rchk("page", `PMM_REG_PAGE, 32'hFFFFFFFF, 32'h0);
        rchk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
        // advertisement read before any select
        host.rd(8'h02, q);
        chk("adv_p3", {24'h0, q[15:8] & 8'h04}, 32'h4);
        host.rd(8'hC3, q);
        chk("adv_up", {24'h0, q[15:8] & 8'hC1}, 32'h81);
        // masked event, then unmask and clear by read
        host.wr(`PMM_SEL_ADDR, 8'h01);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wreg(`PMM_REG_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq_raised", {31'h0, irq}, 32'h1);
        rchk("stat_first", `PMM_REG_STAT, 32'h2, 32'h2);
        foreach (bad[i])
        begin
            host.wr(`PMM_SEL_ADDR, 8'h03);
            host.wr(`PMM_SEL_ADDR, bad[i]);
            chk("irq_rej", {31'h0, irq}, 32'h1);
            rchk("page_rej", `PMM_REG_PAGE, 32'hFF, 32'h0);
            rchk("stat_rej", `PMM_REG_STAT, 32'h2, 32'h2);
            repeat (3) @(posedge clk);
            chk("irq_clr", {31'h0, irq}, 32'h0);
        end
        // each upper page keeps its own byte
        foreach (good[i])
        begin
            host.wr(`PMM_SEL_ADDR, good[i]);
            rchk("page_ok", `PMM_REG_PAGE, 32'hFF, {24'h0, good[i]});
            rchk("stat_ok", `PMM_REG_STAT, 32'h4, 32'h4);
            host.wr(8'h80, good[i] ^ 8'h5A);
        end
        foreach (good[i])
        begin
            host.wr(`PMM_SEL_ADDR, good[i]);
            host.rd(8'h7F, q);
            chk("upper", {16'h0, q},
                {16'h0, good[i], good[i] ^ 8'h5A});
        end
        // reserved select lands on read-only page zero
        host.wr(`PMM_SEL_ADDR, 8'h30);
        host.wr(8'h80, 8'hA5);
        host.rd(8'h7F, q);
        chk("id_ro", {16'h0, q}, 32'h0);
        wreg(`PMM_REG_MADR, 32'h080);
        rchk("id_raw", `PMM_REG_MDAT, 32'hFF, 32'h0);
        wreg(`PMM_REG_MADR, 32'h180);
        rchk("p2_raw", `PMM_REG_MDAT, 32'hFF, 32'h58);
        // lower page under any selection, one block read
        host.wr(`PMM_SEL_ADDR, 8'h20);
        host.wr(8'h05, 8'h3C);
        wreg(`PMM_REG_MADR, 32'h006);
        wreg(`PMM_REG_MDAT, 32'h77);
        host.wr(`PMM_SEL_ADDR, 8'h21);
        host.rd(8'h05, q);
        chk("lower_blk", {16'h0, q}, 32'h3C77);
        chk("acks", {31'h0, host.ok}, 32'h1);
        // disabled link refuses the host
        wreg(`PMM_REG_CTRL, 32'h0);
        host.wr(8'h05, 8'h11);
        chk("link_off", {31'h0, host.ok}, 32'h0);
        wreg(`PMM_REG_CTRL, 32'h1);
        host.rd(8'h05, q);
        chk("lower_keep", {24'h0, q[15:8]}, 32'h3C);
        chk("hresp", {31'h0, hresp}, 32'h0);
        test_done;
    end
endmodule

/* tb/pmm_host.sv */
// serial management host model for the two-wire port
module pmm_host
#(
    parameter int H = 4,
    parameter logic [6:0] DEV = 7'h50
)
(
    input wire logic clk,   // system clock
    input wire logic sda,   // data wire level
    output logic scl,       // serial clock, host owned
    output logic sda_low    // high pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ok;
    // ==========================================================
    // clock idles high between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        ok = 1'b1;
    end
    task automatic hp;
        repeat (H) @(posedge clk);
    endtask
    // data only moves while clock is low, so no false start or stop
    task automatic bt(input logic b, output logic r);
        hp;
        sda_low <= !b;
        hp;
        scl <= 1'b1;
        hp;
        r = sda;
        scl <= 1'b0;
    endtask
    // start or repeated start, then stop
    task automatic sr;
        hp;
        sda_low <= 1'b0;
        hp;
        scl <= 1'b1;
        hp;
        sda_low <= 1'b1;
        hp;
        scl <= 1'b0;
    endtask
    task automatic sp;
        hp;
        sda_low <= 1'b1;
        hp;
        scl <= 1'b1;
        hp;
        sda_low <= 1'b0;
        hp;
    endtask
    // one byte and its ninth bit; a missing ack clears ok
    task automatic xb(input logic [7:0] d, input logic l,
                      output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bt(d[i], q[i]);
        bt(l, a);
        if (d != 8'hFF && a)
            ok = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] t;
        sr;
        xb({DEV, 1'b0}, 1'b1, t);
        xb(a, 1'b1, t);
        xb(d, 1'b1, t);
        sp;
    endtask
    // block read of two bytes from the pointer
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        logic [7:0] t;
        sr;
        xb({DEV, 1'b0}, 1'b1, t);
        xb(a, 1'b1, t);
        sr;
        xb({DEV, 1'b1}, 1'b1, t);
        xb(8'hFF, 1'b0, q[15:8]);
        xb(8'hFF, 1'b1, q[7:0]);
        sp;
    endtask
endmodule

/* tb/pmm_props.sv */
// bus and serial port checks for the paged management memory
`include "pmm_defs.vh"
module pmm_chk
(
    input wire I_CLOCK,         // system clock
    input wire I_RESET,         // async reset, high
    input wire I_HSEL,          // slave select
    input wire [31:0] I_HADDR,  // byte address
    input wire [1:0] I_HTRANS,  // transfer type
    input wire I_HWRITE,        // write when high
    input wire [31:0] I_HWDATA, // write data
    input wire I_HREADY,        // bus ready
    input wire [31:0] O_HRDATA, // read data
    input wire O_HREADYOUT,     // slave ready
    input wire O_HRESP,         // response
    input wire I_SCL,           // serial clock
    input wire O_SDA,           // serial drive value
    input wire O_SDA_OE_N,      // serial drive enable, low
    input wire O_IRQ            // level interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RESET);
    logic take;
    logic dp_q;
    logic wr_q;
    logic mk_q;
    logic quiet;
    logic [2:0] mask_sh;
    // ==========================================================
    // shadow of the mask; a pending write counts as not quiet
    assign take = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign quiet = (mask_sh == 3'h0) && !mk_q;
    always @(posedge I_CLOCK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            dp_q <= 1'b0;
            wr_q <= 1'b0;
            mk_q <= 1'b0;
            mask_sh <= 3'h0;
        end
        else
        begin
            if (dp_q && O_HREADYOUT)
            begin
                dp_q <= 1'b0;
                mk_q <= 1'b0;
                if (mk_q)
                    mask_sh <= I_HWDATA[2:0];
            end
            if (take)
            begin
                dp_q <= 1'b1;
                wr_q <= I_HWRITE;
                mk_q <= I_HWRITE && (I_HADDR[7:0] == `PMM_REG_MASK);
            end
        end
    end
    // ==========================================================
    // properties, clocked and gated by the defaults at the top
    a_resp_okay: assert property (O_HRESP == 1'b0)
        else $error("bus response not okay");
    a_ready_drop: assert property (take |=> !O_HREADYOUT)
        else $error("ready stayed high after a request");
    a_ready_back: assert property
        (!O_HREADYOUT |-> ##[1:2] O_HREADYOUT)
        else $error("data phase too long");
    a_ready_idle: assert property
        (O_HREADYOUT && !take |=> O_HREADYOUT)
        else $error("ready dropped with no request");
    a_rdata_hold: assert property
        (!$rose(O_HREADYOUT) |-> $stable(O_HRDATA))
        else $error("read data moved outside completion");
    a_write_zero: assert property
        (dp_q && wr_q && O_HREADYOUT |-> O_HRDATA == 32'h0)
        else $error("write did not zero read data");
    a_sda_value: assert property (O_SDA == 1'b0)
        else $error("data line driven high");
    a_oe_scl_low: assert property
        ($changed(O_SDA_OE_N) |-> !$past(I_SCL, 2))
        else $error("data drive changed while clock high");
    a_irq_masked: assert property
        (quiet && $past(quiet) |-> !O_IRQ)
        else $error("interrupt with all events masked");
endmodule

bind pmm_top pmm_chk u_chk (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
    .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
    .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_SCL(I_SCL), .O_SDA(O_SDA), .O_SDA_OE_N(O_SDA_OE_N),
    .O_IRQ(O_IRQ));
